/* File: hw/bec_pkg.sv */
package bec_pkg;

  // boot mode strap encodings
  localparam logic [1:0] BEC_BOOT_HOST = 2'h0;
  localparam logic [1:0] BEC_BOOT_EMU  = 2'h1;
  localparam logic [1:0] BEC_BOOT_ROM  = 2'h2;

  // rom width strap encodings
  localparam logic [1:0] BEC_WIDTH_8  = 2'h0;
  localparam logic [1:0] BEC_WIDTH_16 = 2'h1;
  localparam logic [1:0] BEC_WIDTH_32 = 2'h2;

  // boot image geometry
  localparam int          BEC_IMAGE_BYTES = 1024;
  localparam int          BEC_IMAGE_WORDS = BEC_IMAGE_BYTES / 4;
  localparam logic [27:0] BEC_ROM_BASE    = 28'h0000000;
  localparam logic [27:0] BEC_DEST_BASE   = 28'h0000000;
  localparam logic [31:0] BEC_BOOT_PC     = 32'h00000000;

  // strap defaults
  localparam logic BEC_LITTLE_DEFAULT = 1'h1;
  localparam logic BEC_LANE_DEFAULT   = 1'h1;

  typedef struct packed {
    logic [1:0] boot_mode;
    logic       little_endian_select;
    logic       lane_correction_strap;
    logic [1:0] rom_width;
  } bec_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [27:0] addr;
    logic [31:0] data;
  } bec_wr_t;

endpackage

/* File: hw/bec_lane_map.sv */
`timescale 1ns/1ps
module bec_lane_map
  import bec_pkg::*;
(
  input  wire logic        little_endian_select,
  input  wire logic        lane_correction_strap,
  input  wire logic [1:0]  width,
  input  wire logic [15:0] narrow_in,
  output logic      [31:0] lanes_out
);

  always_comb begin
    lanes_out = 32'h00000000;
    if (width == BEC_WIDTH_32) begin
      lanes_out = {16'h0000, narrow_in};
    end else if (little_endian_select || !lane_correction_strap) begin
      lanes_out = (width == BEC_WIDTH_8) ? {24'h000000, narrow_in[7:0]}
                                         : {16'h0000, narrow_in};
    end else begin
      lanes_out = (width == BEC_WIDTH_8) ? {narrow_in[7:0], 24'h000000}
                                         : {narrow_in, 16'h0000};
    end
  end

endmodule // bec_lane_map

/* File: hw/bec_boot_seq.sv */
`timescale 1ns/1ps
// How it works
// - endian strap picks order, little default
// - big endian default: narrow data top lanes
// - correction low: narrow data low lanes
// - le or correction low: placement unchanged
// - reset holds all; release starts boot
// - three modes: host, emulation, rom
// - host boot stalls cpu, rest released
// - host flag releases stall at zero
// - flag during stall not an interrupt
// - host may read and write memory
// - flag held until cpu clears it
// - rom boot copies 1 KB to zero
// - narrow rom packed into 32-bit words
// - single block copy then release cpu
module bec_boot_seq
  import bec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        reset_n_pin,
  input  wire logic [1:0]  boot_mode_strap,
  input  wire logic        endian_select_strap,
  input  wire logic        lane_correction_strap,
  input  wire logic [1:0]  rom_width_strap,
  input  wire logic        host_flag_set,
  input  wire logic        cpu_flag_clear,
  input  wire logic        rom_rd_ack,
  input  wire logic [31:0] rom_rd_data,
  input  wire logic        mem_wr_ready,
  input  wire logic [15:0] narrow_tx_data,
  input  wire logic [1:0]  narrow_tx_width,
  output logic             internal_reset,
  output logic             cpu_stall,
  output logic [31:0]      cpu_start_pc,
  output logic             cpu_interrupt,
  output logic             host_to_cpu_flag,
  output logic             host_mem_access_en,
  output logic             little_endian_select,
  output logic             narrow_data_lane_correction,
  output logic             rom_rd_req,
  output logic [27:0]      rom_rd_addr,
  output bec_wr_t          mem_wr,
  output logic [31:0]      ext_data_lines,
  output logic             boot_done
);

  typedef enum logic [2:0] {
    BEC_S_RESET = 3'b000,
    BEC_S_HOST  = 3'b001,
    BEC_S_READ  = 3'b010,
    BEC_S_WAIT  = 3'b011,
    BEC_S_WRITE = 3'b100,
    BEC_S_RUN   = 3'b101
  } bec_state_t;

  function automatic logic [2:0] bec_step(input logic [1:0] w);
    case (w)
      BEC_WIDTH_8:  bec_step = 3'h1;
      BEC_WIDTH_16: bec_step = 3'h2;
      default:      bec_step = 3'h4;
    endcase
  endfunction

  bec_state_t  state_r, state_nxt;
  bec_cfg_t    cfg_r, cfg_nxt;
  logic        ireset_r, ireset_nxt;
  logic        stall_r, stall_nxt;
  logic        flag_r, flag_nxt;
  logic        irq_r, irq_nxt;
  logic [27:0] raddr_r, raddr_nxt;
  logic [2:0]  bcnt_r, bcnt_nxt;
  logic [31:0] word_r, word_nxt;
  logic [8:0]  wcnt_r, wcnt_nxt;
  logic        rreq_r, rreq_nxt;
  bec_wr_t     wr_r, wr_nxt;
  logic        done_r, done_nxt;
  logic [31:0] lanes_c, lanes_r;
  logic [31:0] packed_c;
  logic [2:0]  step_c;

  bec_lane_map u_lane (
    .little_endian_select  (cfg_r.little_endian_select),
    .lane_correction_strap (cfg_r.lane_correction_strap),
    .width                 (narrow_tx_width),
    .narrow_in             (narrow_tx_data),
    .lanes_out             (lanes_c)
  );

  always_comb begin
    step_c   = bec_step(cfg_r.rom_width);
    packed_c = word_r;
    case (cfg_r.rom_width)
      BEC_WIDTH_8:  packed_c = cfg_r.little_endian_select
                    ? {rom_rd_data[7:0], word_r[31:8]} : {word_r[23:0], rom_rd_data[7:0]};
      BEC_WIDTH_16: packed_c = cfg_r.little_endian_select
                    ? {rom_rd_data[15:0], word_r[31:16]} : {word_r[15:0], rom_rd_data[15:0]};
      default:      packed_c = rom_rd_data;
    endcase
  end

  always_comb begin
    state_nxt  = state_r;
    cfg_nxt    = cfg_r;
    ireset_nxt = ireset_r;
    stall_nxt  = stall_r;
    flag_nxt   = flag_r;
    irq_nxt    = 1'b0;
    raddr_nxt  = raddr_r;
    bcnt_nxt   = bcnt_r;
    word_nxt   = word_r;
    wcnt_nxt   = wcnt_r;
    rreq_nxt   = rreq_r;
    wr_nxt     = wr_r;
    done_nxt   = done_r;
    if (cpu_flag_clear)
      flag_nxt = 1'b0;
    if (host_flag_set) begin
      flag_nxt = 1'b1;
      if (!stall_r && !flag_r)
        irq_nxt = 1'b1;
    end
    case (state_r)
      BEC_S_RESET: begin
        cfg_nxt.boot_mode             = boot_mode_strap;
        cfg_nxt.little_endian_select  = endian_select_strap;
        cfg_nxt.lane_correction_strap = lane_correction_strap;
        cfg_nxt.rom_width             = rom_width_strap;
        ireset_nxt = 1'b1;
        stall_nxt  = 1'b1;
        if (reset_n_pin) begin
          ireset_nxt = 1'b0;
          raddr_nxt  = BEC_ROM_BASE;
          wcnt_nxt   = 9'h000;
          bcnt_nxt   = 3'h0;
          state_nxt  = (boot_mode_strap == BEC_BOOT_ROM) ? BEC_S_READ : BEC_S_HOST;
        end
      end
      BEC_S_HOST: begin
        // flag ends host or emulation boot
        if (host_flag_set || flag_r) begin
          stall_nxt = 1'b0;
          done_nxt  = 1'b1;
          state_nxt = BEC_S_RUN;
        end
      end
      BEC_S_READ: begin
        rreq_nxt  = 1'b1;
        state_nxt = BEC_S_WAIT;
      end
      BEC_S_WAIT: begin
        if (rom_rd_ack) begin
          rreq_nxt  = 1'b0;
          word_nxt  = packed_c;
          raddr_nxt = raddr_r + 28'(step_c);
          bcnt_nxt  = bcnt_r + step_c;
          if (3'(bcnt_r + step_c) >= 3'h4 || step_c == 3'h4) begin
            bcnt_nxt = 3'h0;
            wr_nxt.valid = 1'b1;
            wr_nxt.addr  = BEC_DEST_BASE + {17'h00000, wcnt_r, 2'h0};
            wr_nxt.data  = packed_c;
            state_nxt    = BEC_S_WRITE;
          end else begin
            state_nxt = BEC_S_READ;
          end
        end
      end
      BEC_S_WRITE: begin
        if (mem_wr_ready) begin
          wr_nxt.valid = 1'b0;
          wcnt_nxt     = wcnt_r + 9'h001;
          if (wcnt_r == 9'(BEC_IMAGE_WORDS - 1)) begin
            stall_nxt = 1'b0;
            done_nxt  = 1'b1;
            state_nxt = BEC_S_RUN;
          end else begin
            state_nxt = BEC_S_READ;
          end
        end
      end
      BEC_S_RUN: begin
        state_nxt = BEC_S_RUN;
      end
      default: state_nxt = BEC_S_RESET;
    endcase
    if (!reset_n_pin)
      state_nxt = BEC_S_RESET;
  end

  always_ff @(posedge clock) begin
    if (rst || !reset_n_pin) begin
      state_r  <= BEC_S_RESET;
      ireset_r <= 1'b1;
      stall_r  <= 1'b1;
      flag_r   <= 1'b0;
      irq_r    <= 1'b0;
      raddr_r  <= 28'h0000000;
      bcnt_r   <= 3'h0;
      word_r   <= 32'h00000000;
      wcnt_r   <= 9'h000;
      rreq_r   <= 1'b0;
      wr_r     <= '0;
      done_r   <= 1'b0;
      lanes_r  <= 32'h00000000;
      cfg_r    <= '{boot_mode: BEC_BOOT_HOST, little_endian_select: BEC_LITTLE_DEFAULT,
                    lane_correction_strap: BEC_LANE_DEFAULT, rom_width: BEC_WIDTH_32};
      if (!rst)
        cfg_r <= cfg_nxt;
    end else begin
      state_r  <= state_nxt;
      cfg_r    <= cfg_nxt;
      ireset_r <= ireset_nxt;
      stall_r  <= stall_nxt;
      flag_r   <= flag_nxt;
      irq_r    <= irq_nxt;
      raddr_r  <= raddr_nxt;
      bcnt_r   <= bcnt_nxt;
      word_r   <= word_nxt;
      wcnt_r   <= wcnt_nxt;
      rreq_r   <= rreq_nxt;
      wr_r     <= wr_nxt;
      done_r   <= done_nxt;
      lanes_r  <= lanes_c;
    end
  end

  assign internal_reset              = ireset_r;
  assign cpu_stall                   = stall_r;
  assign cpu_start_pc                = BEC_BOOT_PC;
  assign cpu_interrupt               = irq_r;
  assign host_to_cpu_flag            = flag_r;
  // host memory access always enabled, every mode
  assign host_mem_access_en          = 1'b1;
  assign little_endian_select        = cfg_r.little_endian_select;
  assign narrow_data_lane_correction = ~cfg_r.lane_correction_strap;
  assign rom_rd_req                  = rreq_r;
  assign rom_rd_addr                 = raddr_r;
  assign mem_wr                      = wr_r;
  assign ext_data_lines              = lanes_r;
  assign boot_done                   = done_r;

  property p_no_irq_stalled;
    @(posedge clock) disable iff (rst)
    $rose(cpu_interrupt) |-> !$past(stall_r);
  endproperty
  a_no_irq_stalled: assert property (p_no_irq_stalled) else $error("irq during stall");

  property p_flag_hold;
    @(posedge clock) disable iff (rst || !reset_n_pin)
    (flag_r && !cpu_flag_clear) |=> flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  property p_host_release;
    @(posedge clock) disable iff (rst || !reset_n_pin)
    (state_r == BEC_S_HOST && host_flag_set) |=> (!cpu_stall && boot_done);
  endproperty
  a_host_release: assert property (p_host_release) else $error("host boot not released");

  property p_ireset;
    @(posedge clock) disable iff (rst)
    !reset_n_pin |=> (internal_reset && cpu_stall);
  endproperty
  a_ireset: assert property (p_ireset) else $error("reset not held");

  property p_cfg_stable;
    @(posedge clock) disable iff (rst || !reset_n_pin)
    !internal_reset |=> $stable(cfg_r);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("strap changed");

  // rom boot stalls until last write
  property p_rom_stall;
    @(posedge clock) disable iff (rst || !reset_n_pin)
    (state_r == BEC_S_READ || state_r == BEC_S_WAIT) |-> cpu_stall;
  endproperty
  a_rom_stall: assert property (p_rom_stall) else $error("cpu released mid copy");

  property p_copy_range;
    @(posedge clock) disable iff (rst || !reset_n_pin)
    mem_wr.valid |-> (mem_wr.addr < 28'h0000400);
  endproperty
  a_copy_range: assert property (p_copy_range) else $error("copy out of range");

  // big endian uncorrected byte high lanes
  property p_be_lanes;
    @(posedge clock) disable iff (rst)
    (!cfg_r.little_endian_select && cfg_r.lane_correction_strap
     && narrow_tx_width == BEC_WIDTH_8) |=> (ext_data_lines[23:0] == 24'h000000);
  endproperty
  a_be_lanes: assert property (p_be_lanes) else $error("big endian lanes wrong");

  property p_corr_lanes;
    @(posedge clock) disable iff (rst)
    (!cfg_r.lane_correction_strap && narrow_tx_width == BEC_WIDTH_8)
    |=> (ext_data_lines[31:8] == 24'h000000);
  endproperty
  a_corr_lanes: assert property (p_corr_lanes) else $error("corrected lanes wrong");

endmodule // bec_boot_seq

/* File: tb/bec_rom_model.sv */
`timescale 1ns/1ps
module bec_rom_model
  import bec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        rom_rd_req,
  input  wire logic [27:0] rom_rd_addr,
  input  wire logic        little,
  input  wire logic [1:0]  width,
  input  wire logic        slow,
  output logic             rom_rd_ack,
  output logic [31:0]      rom_rd_data,
  output logic             mem_wr_ready
);
  logic [1:0] wait_r;
  function automatic logic [7:0] bt(input logic [27:0] a);
    return a[7:0] ^ {a[9:8], 6'h00} ^ 8'ha5;
  endfunction
  function automatic logic [31:0] rd_word(input logic [27:0] a);
    if (width == BEC_WIDTH_8) return {24'hc3c3c3, bt(a)};
    if (width == BEC_WIDTH_16) return little ? {16'hc3c3, bt(a + 1), bt(a)} :
                                               {16'hc3c3, bt(a), bt(a + 1)};
    return little ? {bt(a + 3), bt(a + 2), bt(a + 1), bt(a)} :
                    {bt(a), bt(a + 1), bt(a + 2), bt(a + 3)};
  endfunction
  always_ff @(posedge clock) begin
    if (rst) begin
      rom_rd_ack   <= 1'h0;
      rom_rd_data  <= 32'h0;
      mem_wr_ready <= 1'h0;
      wait_r       <= 2'h0;
    end else begin
      mem_wr_ready <= slow ? ~mem_wr_ready : 1'h1;
      if (rom_rd_req && !rom_rd_ack && wait_r == (slow ? 2'h3 : 2'h0)) begin
        rom_rd_ack  <= 1'h1;
        rom_rd_data <= rd_word(rom_rd_addr);
        wait_r      <= 2'h0;
      end else begin
        rom_rd_ack  <= 1'h0;
        rom_rd_data <= ~rom_rd_data;
        if (rom_rd_req && !rom_rd_ack) wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // bec_rom_model

/* File: tb/boot_and_endian_config_test.sv */
`timescale 1ns/1ps
module boot_and_endian_config_test
  import bec_pkg::*;
;
  typedef struct packed {logic le; logic lc; logic [1:0] w; logic [31:0] exp;} bec_row_t;
  logic clock = 0, rst = 1, reset_n_pin = 0, endian_select_strap = 1, lane_correction_strap = 1;
  logic host_flag_set = 0, cpu_flag_clear = 0, slow = 0, rom_rd_ack, mem_wr_ready, rom_rd_req;
  logic [1:0] boot_mode_strap = BEC_BOOT_HOST, rom_width_strap = BEC_WIDTH_32, narrow_tx_width = 0;
  logic [15:0] narrow_tx_data = 0;
  logic [31:0] rom_rd_data, cpu_start_pc, ext_data_lines;
  logic [27:0] rom_rd_addr;
  logic internal_reset, cpu_stall, cpu_interrupt, host_to_cpu_flag, host_mem_access_en;
  logic little_endian_select, narrow_data_lane_correction, boot_done;
  bec_wr_t mem_wr;
  int errors = 0, cmp_count = 0, widx = 0, n;
  bec_row_t rows [8] = '{
    '{1, 1, BEC_WIDTH_8, 32'h0000003e}, '{1, 1, BEC_WIDTH_16, 32'h00009c3e},
    '{1, 0, BEC_WIDTH_8, 32'h0000003e}, '{1, 0, BEC_WIDTH_16, 32'h00009c3e},
    '{0, 1, BEC_WIDTH_8, 32'h3e000000}, '{0, 1, BEC_WIDTH_16, 32'h9c3e0000},
    '{0, 0, BEC_WIDTH_8, 32'h0000003e}, '{0, 0, BEC_WIDTH_16, 32'h00009c3e}};
  always #10 clock = ~clock;
  bec_boot_seq i_dut (.clock(clock), .rst(rst), .reset_n_pin(reset_n_pin),
    .boot_mode_strap(boot_mode_strap), .endian_select_strap(endian_select_strap),
    .lane_correction_strap(lane_correction_strap), .rom_width_strap(rom_width_strap),
    .host_flag_set(host_flag_set), .cpu_flag_clear(cpu_flag_clear), .rom_rd_ack(rom_rd_ack),
    .rom_rd_data(rom_rd_data), .mem_wr_ready(mem_wr_ready), .narrow_tx_data(narrow_tx_data),
    .narrow_tx_width(narrow_tx_width), .internal_reset(internal_reset), .cpu_stall(cpu_stall),
    .cpu_start_pc(cpu_start_pc), .cpu_interrupt(cpu_interrupt),
    .host_to_cpu_flag(host_to_cpu_flag), .host_mem_access_en(host_mem_access_en),
    .little_endian_select(little_endian_select),
    .narrow_data_lane_correction(narrow_data_lane_correction), .rom_rd_req(rom_rd_req),
    .rom_rd_addr(rom_rd_addr), .mem_wr(mem_wr), .ext_data_lines(ext_data_lines),
    .boot_done(boot_done));
  bec_rom_model i_rom (.clock(clock), .rst(rst), .rom_rd_req(rom_rd_req),
    .rom_rd_addr(rom_rd_addr), .little(endian_select_strap), .width(rom_width_strap),
    .slow(slow), .rom_rd_ack(rom_rd_ack), .rom_rd_data(rom_rd_data),
    .mem_wr_ready(mem_wr_ready));
  function automatic logic [7:0] bt(input int a);
    return a[7:0] ^ {a[9:8], 6'h00} ^ 8'ha5;
  endfunction
  function automatic logic [31:0] exp_word(input int i);
    if (endian_select_strap) return {bt(4 * i + 3), bt(4 * i + 2), bt(4 * i + 1), bt(4 * i)};
    return {bt(4 * i), bt(4 * i + 1), bt(4 * i + 2), bt(4 * i + 3)};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic restart();
    reset_n_pin = 0;
    step(1);
    chk("internal_reset", internal_reset, 1);
    step(1);
    reset_n_pin = 1;
    step(1);
  endtask
  task automatic pulse_set(output int cnt);
    cnt = 0;
    host_flag_set = 1;
    step(1);
    host_flag_set = 0;
    repeat (3) begin
      if (cpu_interrupt === 1'b1) cnt++;
      step(1);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock) begin
    if (mem_wr.valid === 1'b1 && mem_wr_ready === 1'b1) begin
      chk("wr_data", mem_wr.data, exp_word(widx));
      chk("wr_addr", {4'h0, mem_wr.addr}, 32'(widx * 4));
      chk("stall_copy", cpu_stall, 1);
      widx++;
    end
  end
  initial begin
    step(3);
    chk("little_default", little_endian_select, BEC_LITTLE_DEFAULT);
    rst = 0;
    foreach (rows[i]) begin
      endian_select_strap = rows[i].le;
      lane_correction_strap = rows[i].lc;
      restart();
      chk("little", little_endian_select, rows[i].le);
      chk("corr", narrow_data_lane_correction, !rows[i].lc);
      narrow_tx_width = rows[i].w;
      narrow_tx_data = 16'h9c3e;
      step(2);
      chk("lanes", ext_data_lines, rows[i].exp);
    end
    endian_select_strap = 1;
    step(2);
    chk("strap_held", little_endian_select, 0);
    restart();
    chk("internal_rel", internal_reset, 0);
    step(3);
    chk("host_stall", cpu_stall, 1);
    chk("mem_access", host_mem_access_en, 1);
    pulse_set(n);
    chk("stall_irq", n, 0);
    chk("released", cpu_stall, 0);
    chk("start_pc", cpu_start_pc, BEC_BOOT_PC);
    pulse_set(n);
    chk("irq_while_set", n, 0);
    chk("flag_sticky", host_to_cpu_flag, 1);
    cpu_flag_clear = 1;
    step(1);
    cpu_flag_clear = 0;
    chk("flag_clear", host_to_cpu_flag, 0);
    pulse_set(n);
    chk("irq_once", n, 1);
    rst = 1;
    step(1);
    chk("mid_reset", {internal_reset, cpu_stall, boot_done, host_to_cpu_flag}, 4'hc);
    rst = 0;
    boot_mode_strap = BEC_BOOT_EMU;
    restart();
    step(2);
    chk("emu_stall", cpu_stall, 1);
    pulse_set(n);
    chk("emu_release", cpu_stall, 0);
    boot_mode_strap = BEC_BOOT_ROM;
    for (int m = 0; m < 6; m++) begin
      rom_width_strap = 2'(m % 3);
      endian_select_strap = (m < 3);
      slow = m[0];
      widx = 0;
      restart();
      pulse_set(n);
      chk("rom_flag_stall", cpu_stall, 1);
      for (int t = 0; t < 12000 && boot_done !== 1'b1; t++) step(1);
      if (boot_done !== 1'b1) begin
        errors++;
        complete_run();
      end
      chk("word_count", widx, BEC_IMAGE_WORDS);
      chk("rom_release", cpu_stall, 0);
    end
    complete_run();
  end
endmodule // boot_and_endian_config_test
